// ===== hdl/cvs_clock_mux.sv
// glitch-free selector between the slow and fast oscillator levels
`timescale 1ns/100ps
module cvs_clock_mux (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic slow_lvl,
  input wire logic fast_lvl,
  input wire logic sel_fast,
  output logic clk_out,
  output logic on_fast,
  output logic switching
);

  typedef struct packed {
    cvs_pkg::cvs_mux_state_t st;
    logic cur_fast;
    logic out;
  } cvs_mux_reg_t;

  cvs_mux_reg_t r;
  cvs_mux_reg_t next_r;
  logic cur_lvl;
  logic new_lvl;

  // source levels as seen from the current and the requested side
  assign cur_lvl = r.cur_fast ? fast_lvl : slow_lvl;
  assign new_lvl = r.cur_fast ? slow_lvl : fast_lvl;

  // leave the old source only while it is low, join the new one only while it is low;
  // low phases may stretch, no high or low phase is ever cut short
  always_comb begin
    next_r = r;
    unique case (r.st)
      cvs_pkg::CVS_MUX_FOLLOW: begin
        next_r.out = cur_lvl;
        if ((sel_fast != r.cur_fast) && !cur_lvl) begin
          next_r.st = cvs_pkg::CVS_MUX_HOLD;
          next_r.out = 1'b0;
        end
      end
      cvs_pkg::CVS_MUX_HOLD: begin
        next_r.out = 1'b0;
        if (sel_fast == r.cur_fast) begin
          // request withdrawn: rejoin old source at its low phase
          if (!cur_lvl) begin
            next_r.st = cvs_pkg::CVS_MUX_FOLLOW;
          end
        end else if (!new_lvl) begin
          next_r.cur_fast = ~r.cur_fast;
          next_r.st = cvs_pkg::CVS_MUX_FOLLOW;
        end
      end
    endcase
  end

  // a stopped new source keeps the output parked low until it runs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r.st <= cvs_pkg::CVS_MUX_FOLLOW;
      r.cur_fast <= 1'b0;
      r.out <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign clk_out = r.out;
  assign on_fast = r.cur_fast;
  assign switching = (r.st == cvs_pkg::CVS_MUX_HOLD);

endmodule // cvs_clock_mux

// ===== hdl/cvs_clock_voltage_switch.sv
// top of the processor clock source and core supply level switch
//
// Summary of operation
// - D0 selects core supply high or low
// - resistor-capacitor slow oscillator pins supply high
// - D2 starts and stops the fast oscillator
// - D3 picks fast or slow processor clock
// - low supply, fast off: write selecting fast clock refused
// - resistor-capacitor type never blocks fast clock
// - D1 unused, always reads zero
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module cvs_clock_voltage_switch #(
  parameter bit SLOW_OSC_IS_RC = 1'b0,
  parameter int ALIVE_WINDOW = cvs_pkg::ALIVE_WINDOW_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [cvs_pkg::ADDR_W-1:0] addr,
  input wire logic [cvs_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [cvs_pkg::DATA_W-1:0] rd_data,
  input wire logic slow_osc_in,
  input wire logic fast_osc_in,
  output logic core_supply_high,
  output logic fast_osc_on,
  output logic cpu_clk,
  output logic cpu_clk_on_fast,
  output logic clk_write_refused
);

  localparam int ALIVE_W = $clog2(ALIVE_WINDOW + 1);
  localparam logic [ALIVE_W-1:0] ALIVE_MAX = ALIVE_W'(ALIVE_WINDOW);
  localparam logic [ALIVE_W-1:0] ALIVE_ONE = ALIVE_W'(1);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic supply_sel;
    logic fast_en;
    logic clk_sel;
    logic supply_out;
    logic refused;
    logic fast_prev;
    logic [ALIVE_W-1:0] idle_cnt;
    logic [cvs_pkg::DATA_W-1:0] rd;
  } cvs_top_reg_t;

  cvs_top_reg_t r;
  cvs_top_reg_t next_r;

  logic [1:0] osc_sync;
  logic slow_lvl;
  logic fast_lvl;
  logic mux_on_fast;
  logic mux_switching;
  logic ctrl_wr;
  logic clk_block;
  logic fast_alive;
  logic [cvs_pkg::DATA_W-1:0] ctrl_view;
  logic [cvs_pkg::DATA_W-1:0] stat_view;

  // ****************************************
  // oscillator inputs
  // ****************************************
  // the slow oscillator runs freely, the fast one only while D2 enables it; both pins are sampled as levels
  cvs_sync2 #(
    .WIDTH(2)
  ) u_osc_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({fast_osc_in, slow_osc_in}),
    .sync_out(osc_sync)
  );

  assign slow_lvl = osc_sync[0];
  assign fast_lvl = osc_sync[1];

  // ****************************************
  // processor clock selector
  // ****************************************
  // sampled at 50 MHz, so a 4 MHz source keeps about a dozen samples per period
  cvs_clock_mux u_clk_mux (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .slow_lvl(slow_lvl),
    .fast_lvl(fast_lvl),
    .sel_fast(r.clk_sel),
    .clk_out(cpu_clk),
    .on_fast(mux_on_fast),
    .switching(mux_switching)
  );

  // ****************************************
  // decode and views
  // ****************************************
  assign ctrl_wr = wr_stb && (addr == cvs_pkg::CTRL_ADDR);
  // stored values judge the write, not the bits arriving with it
  assign clk_block = !(r.supply_sel || SLOW_OSC_IS_RC) && !r.fast_en;
  assign fast_alive = (r.idle_cnt != ALIVE_MAX);

  // control view: D1 has no storage
  always_comb begin
    ctrl_view = cvs_pkg::READ_ZERO;
    ctrl_view[cvs_pkg::SUPPLY_BIT] = r.supply_sel;
    ctrl_view[cvs_pkg::FAST_EN_BIT] = r.fast_en;
    ctrl_view[cvs_pkg::CLK_SEL_BIT] = r.clk_sel;
  end

  // status view of the running switch
  always_comb begin
    stat_view = cvs_pkg::READ_ZERO;
    stat_view[cvs_pkg::STAT_ON_FAST_BIT] = mux_on_fast;
    stat_view[cvs_pkg::STAT_SWITCHING_BIT] = mux_switching;
    stat_view[cvs_pkg::STAT_FAST_ALIVE_BIT] = fast_alive;
    stat_view[cvs_pkg::STAT_SUPPLY_HIGH_BIT] = r.supply_out;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.refused = 1'b0;
    // read data stand one cycle, zero otherwise and for unmapped addresses
    next_r.rd = cvs_pkg::READ_ZERO;
    if (rd_stb) begin
      if (addr == cvs_pkg::CTRL_ADDR) begin
        next_r.rd = ctrl_view;
      end else if (addr == cvs_pkg::STAT_ADDR) begin
        next_r.rd = stat_view;
      end
    end
    if (ctrl_wr) begin
      next_r.supply_sel = wr_data[cvs_pkg::SUPPLY_BIT];
      next_r.fast_en = wr_data[cvs_pkg::FAST_EN_BIT];
      if (wr_data[cvs_pkg::CLK_SEL_BIT] && clk_block) begin
        next_r.refused = 1'b1;
      end else begin
        next_r.clk_sel = wr_data[cvs_pkg::CLK_SEL_BIT];
      end
    end
    // supply level follows the bit unless the slow oscillator is the rc type
    next_r.supply_out = SLOW_OSC_IS_RC | next_r.supply_sel;
    // fast oscillator activity: count cycles since its last edge
    next_r.fast_prev = fast_lvl;
    if (fast_lvl != r.fast_prev) begin
      next_r.idle_cnt = '0;
    end else if (r.idle_cnt != ALIVE_MAX) begin
      next_r.idle_cnt = r.idle_cnt + ALIVE_ONE;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r.supply_sel <= 1'b0;
      r.fast_en <= 1'b0;
      r.clk_sel <= 1'b0;
      r.supply_out <= SLOW_OSC_IS_RC;
      r.refused <= 1'b0;
      r.fast_prev <= 1'b0;
      r.idle_cnt <= ALIVE_MAX;
      r.rd <= cvs_pkg::READ_ZERO;
    end else begin
      r <= next_r;
    end
  end

  assign rd_data = r.rd;
  assign core_supply_high = r.supply_out;
  assign fast_osc_on = r.fast_en;
  assign cpu_clk_on_fast = mux_on_fast;
  assign clk_write_refused = r.refused;

endmodule // cvs_clock_voltage_switch

// ===== hdl/cvs_pkg.sv
// package: register map, field positions and state codes of the clock and supply switch
package cvs_pkg;

  // ****************************************
  // register bus
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 4;
  localparam logic [15:0] CTRL_ADDR = 16'hFF00; // clock_and_supply_control
  localparam logic [15:0] STAT_ADDR = 16'hFF01; // switch status, read only

  // ****************************************
  // clock_and_supply_control fields
  // ****************************************
  localparam int SUPPLY_BIT = 0;
  localparam int FAST_EN_BIT = 2;
  localparam int CLK_SEL_BIT = 3;
  localparam logic [3:0] READ_ZERO = 4'h0;

  // ****************************************
  // status register fields
  // ****************************************
  localparam int STAT_ON_FAST_BIT = 0;
  localparam int STAT_SWITCHING_BIT = 1;
  localparam int STAT_FAST_ALIVE_BIT = 2;
  localparam int STAT_SUPPLY_HIGH_BIT = 3;

  // ****************************************
  // defaults
  // ****************************************
  localparam int ALIVE_WINDOW_DEF = 256; // core cycles without a fast edge before "dead"

  // ****************************************
  // clock multiplexer states
  // ****************************************
  typedef enum logic [1:0] {
    CVS_MUX_FOLLOW = 2'b01,
    CVS_MUX_HOLD = 2'b10
  } cvs_mux_state_t;

endpackage

// ===== hdl/cvs_sync2.sv
// two-stage synchroniser for levels arriving from outside the core clock
`timescale 1ns/100ps
module cvs_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } cvs_sync_state_t;

  cvs_sync_state_t r;
  cvs_sync_state_t next_r;

  // stage1 is read only by stage2, never by logic
  always_comb begin
    next_r = r;
    next_r.stage1 = async_in;
    next_r.stage2 = r.stage1;
  end

  // synchronous reset clears both stages
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.stage2;

endmodule // cvs_sync2

// ===== tb/cvs_monitor.sv
// checker: port-level assertions for the clock and supply switch
`timescale 1ns/100ps
module cvs_monitor #(
  parameter bit SLOW_OSC_IS_RC = 1'b0,
  parameter int ALIVE_WINDOW = cvs_pkg::ALIVE_WINDOW_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] addr,
  input wire logic [3:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [3:0] rd_data,
  input wire logic core_supply_high,
  input wire logic fast_osc_on,
  input wire logic cpu_clk,
  input wire logic cpu_clk_on_fast,
  input wire logic clk_write_refused
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // write to the control word in this cycle
  wire ctl_wr = wr_stb && addr == cvs_pkg::CTRL_ADDR;
  sequence s_refused;
    ctl_wr && wr_data[3] && !core_supply_high && !fast_osc_on;
  endsequence
  // fast already running and kept running by this write
  sequence s_go_fast;
    ctl_wr && wr_data[3] && wr_data[2] && fast_osc_on;
  endsequence
  property p_supply; ctl_wr && !SLOW_OSC_IS_RC |=> core_supply_high == $past(wr_data[0]); endproperty
  a_supply: assert property (p_supply) else $error("supply level not taken");
  property p_rc_fixed; SLOW_OSC_IS_RC |-> core_supply_high; endproperty
  a_rc_fixed: assert property (p_rc_fixed) else $error("supply not fixed high");
  property p_osc_en; ctl_wr |=> fast_osc_on == $past(wr_data[2]); endproperty
  a_osc_en: assert property (p_osc_en) else $error("fast enable not taken");
  property p_to_fast; s_go_fast |-> ##[1:40] cpu_clk_on_fast; endproperty
  a_to_fast: assert property (p_to_fast) else $error("fast clock never selected");
  property p_refuse; !SLOW_OSC_IS_RC ##0 s_refused |=> clk_write_refused && !cpu_clk_on_fast; endproperty
  a_refuse: assert property (p_refuse) else $error("blocked switch not refused");
  property p_rc_free; ctl_wr && wr_data[3] && SLOW_OSC_IS_RC |=> !clk_write_refused; endproperty
  a_rc_free: assert property (p_rc_free) else $error("switch refused on rc type");
  property p_unused; rd_stb && addr == cvs_pkg::CTRL_ADDR |=> !rd_data[1] && rd_data[2] == $past(fast_osc_on); endproperty
  a_unused: assert property (p_unused) else $error("control read wrong");
  // synced sources never stay one cycle, so neither may the output
  property p_pulse; $changed(cpu_clk) |=> $stable(cpu_clk); endproperty
  a_pulse: assert property (p_pulse) else $error("short clock pulse");
endmodule // cvs_monitor

bind cvs_clock_voltage_switch cvs_monitor #(.SLOW_OSC_IS_RC(SLOW_OSC_IS_RC), .ALIVE_WINDOW(ALIVE_WINDOW)) mon_u (
  .core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rd_data(rd_data), .core_supply_high(core_supply_high), .fast_osc_on(fast_osc_on), .cpu_clk(cpu_clk),
  .cpu_clk_on_fast(cpu_clk_on_fast), .clk_write_refused(clk_write_refused));

// ===== tb/tb_cvs_clock_voltage_switch.sv
// testbench: control word table, refused switch, fast round trip, reset
`timescale 1ns/100ps
module tb_cvs_clock_voltage_switch;
  // ****************************************
  // signals and instances
  // ****************************************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [3:0] wr_data = 4'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic slow_osc_in = 1'b0;
  logic fast_osc_in = 1'b0;
  logic [3:0] rd_data;
  logic core_supply_high, fast_osc_on, cpu_clk, cpu_clk_on_fast, clk_write_refused, rc_supply, rc_refused;
  logic clk_seen = 1'b0;
  int clk_toggles = 0;
  int err_count = 0;
  int tests_run = 0;
  typedef struct packed { logic [3:0] w; logic [3:0] r; logic s; logic f; logic x; } cvs_row_t;
  // written word, read back, supply, fast enable, refused
  cvs_row_t rows [8] = '{'{4'h8, 4'h0, 1'b0, 1'b0, 1'b1}, '{4'h1, 4'h1, 1'b1, 1'b0, 1'b0},
    '{4'h5, 4'h5, 1'b1, 1'b1, 1'b0}, '{4'h1, 4'h1, 1'b1, 1'b0, 1'b0}, '{4'h0, 4'h0, 1'b0, 1'b0, 1'b0},
    '{4'hC, 4'h4, 1'b0, 1'b1, 1'b1}, '{4'h0, 4'h0, 1'b0, 1'b0, 1'b0}, '{4'h2, 4'h0, 1'b0, 1'b0, 1'b0}};
  cvs_clock_voltage_switch #(.ALIVE_WINDOW(16)) dut_u (.core_clk(core_clk), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .slow_osc_in(slow_osc_in),
    .fast_osc_in(fast_osc_in), .core_supply_high(core_supply_high), .fast_osc_on(fast_osc_on), .cpu_clk(cpu_clk),
    .cpu_clk_on_fast(cpu_clk_on_fast), .clk_write_refused(clk_write_refused));
  // second copy built with the resistor-capacitor slow oscillator
  cvs_clock_voltage_switch #(.SLOW_OSC_IS_RC(1'b1), .ALIVE_WINDOW(16)) dut_rc (.core_clk(core_clk), .rst_b(rst_b),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(), .slow_osc_in(slow_osc_in),
    .fast_osc_in(fast_osc_in), .core_supply_high(rc_supply), .fast_osc_on(), .cpu_clk(), .cpu_clk_on_fast(),
    .clk_write_refused(rc_refused));
  // ****************************************
  // clocks and tasks
  // ****************************************
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // fast pin only swings while enabled; 55 ns keeps two samples per level
  always #55 fast_osc_in <= fast_osc_on ? ~fast_osc_in : 1'b0;
  always #173 slow_osc_in <= ~slow_osc_in;
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [3:0] exp, input string what);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    check(what, exp, rd_data);
  endtask
  task automatic wait_fast(input logic want);
    int n;
    n = 0;
    while (cpu_clk_on_fast !== want && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    #1;
    check("on fast", {3'h0, want}, {3'h0, cpu_clk_on_fast});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(cvs_pkg::CTRL_ADDR, 4'h0, "ctrl after reset");
    foreach (rows[i]) begin
      wr(cvs_pkg::CTRL_ADDR, rows[i].w);
      check("refused", {3'h0, rows[i].x}, {3'h0, clk_write_refused});
      check("rc refused", 4'h0, {3'h0, rc_refused});
      rd(cvs_pkg::CTRL_ADDR, rows[i].r, "ctrl");
      check("supply", {3'h0, rows[i].s}, {3'h0, core_supply_high});
      check("fast on", {3'h0, rows[i].f}, {3'h0, fast_osc_on});
      check("rc supply", 4'h1, {3'h0, rc_supply});
    end
    // unmapped place takes nothing and reads zero
    wr(16'hFF02, 4'hF);
    rd(16'hFF02, 4'h0, "unmapped");
    rd(cvs_pkg::CTRL_ADDR, 4'h0, "ctrl kept");
    // ordered climb to fast, then back in separate writes
    wr(cvs_pkg::CTRL_ADDR, 4'h1);
    wr(cvs_pkg::CTRL_ADDR, 4'h5);
    // settling waits scaled down; real software waits milliseconds with margin
    repeat (20) @(posedge core_clk);
    wr(cvs_pkg::CTRL_ADDR, 4'hD);
    wait_fast(1'b1);
    // fast source gives several level changes in 20 cycles, slow at most three
    clk_seen = cpu_clk;
    clk_toggles = 0;
    repeat (20) begin
      @(posedge core_clk);
      #1;
      if (cpu_clk !== clk_seen) begin
        clk_toggles++;
      end
      clk_seen = cpu_clk;
    end
    check("clk toggles", 4'h1, {3'h0, clk_toggles > 3});
    rd(cvs_pkg::CTRL_ADDR, 4'hD, "ctrl fast");
    rd(cvs_pkg::STAT_ADDR, 4'hD, "status fast");
    wr(cvs_pkg::CTRL_ADDR, 4'h5);
    wait_fast(1'b0);
    wr(cvs_pkg::CTRL_ADDR, 4'h1);
    check("fast off", 4'h0, {3'h0, fast_osc_on});
    wr(cvs_pkg::CTRL_ADDR, 4'h0);
    check("supply low", 4'h0, {3'h0, core_supply_high});
    // climb again, then reset in mid-run just after the switch request
    wr(cvs_pkg::CTRL_ADDR, 4'h1);
    wr(cvs_pkg::CTRL_ADDR, 4'h5);
    repeat (20) @(posedge core_clk);
    wr(cvs_pkg::CTRL_ADDR, 4'hD);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check("reset out", 4'h0, {core_supply_high, fast_osc_on, cpu_clk_on_fast, cpu_clk});
    @(posedge core_clk);
    rst_b <= 1'b1;
    rd(cvs_pkg::CTRL_ADDR, 4'h0, "ctrl reset");
    rd(cvs_pkg::STAT_ADDR, 4'h0, "status reset");
    tally_and_finish();
  end
  // watchdog well past the few hundred cycles of the sequence
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule // tb_cvs_clock_voltage_switch
